// >>> lwwd_pkg.sv
// Purpose: shared constants for the long-interval wake watchdog timer
// Assumes: 40 MHz system clock, internal oscillator emulated by a divider
// Notes: offsets, field positions, reset values and base timing live here; period factors sit in last_half

package lwwd_pkg;

  // ----------------------------------------------------------------
  // clock and oscillator timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int OSC_PERIOD_NS = 15625000; // one base period, 15.625 ms
  localparam int OSC_HALF_CYCLES = (OSC_PERIOD_NS / 2) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int HDIV_W = 20; // half-period divider width
  localparam int HCNT_W = 14; // half ticks per delay period, up to 8192
  localparam int SEL_W = 3;

  // ----------------------------------------------------------------
  // pulse sequence, in half oscillator periods from period end
  // ----------------------------------------------------------------
  localparam logic [1:0] SEQ_CAL_ON = 2'h1;
  localparam logic [1:0] SEQ_CAL_OFF = 2'h3;
  localparam logic [1:0] SEQ_RST_OFF = 2'h2;
  localparam logic [1:0] SEQ_WAKE_LAST = 2'h3;
  localparam logic [1:0] SEQ_RST_LAST = 2'h2;

  // ----------------------------------------------------------------
  // register map, byte offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_COUNT = 4'h8;

  // ctrl fields
  localparam int CTRL_OVR_EN_BIT = 0;
  localparam int CTRL_SEL_LSB = 1;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // status fields
  localparam int ST_PG_BIT = 0;
  localparam int ST_DROP_BIT = 1;
  localparam int ST_FED_BIT = 2;
  localparam int ST_SEL_LSB = 3;
  localparam int ST_WAKE_BIT = 6;
  localparam int ST_CAL_BIT = 7;
  localparam int ST_HOST_RESET_N_BIT = 8;

  // pulse kinds
  typedef enum logic [1:0] {PK_IDLE, PK_RESET, PK_WAKE} lwwd_pulse_e;

endpackage

// >>> lwwd_sync_if.sv
// Purpose: carries synchronised pin levels and edges into the core
// Assumes: single clock domain on the consumer side
// Notes: driven by lwwd_sync only

`timescale 1ns/1ps
`default_nettype none

interface lwwd_sync_if;
  logic pg_s;
  logic pg_rise;
  logic done_rise;
  logic [lwwd_pkg::SEL_W-1:0] sel_s;

  modport src (output pg_s, output pg_rise, output done_rise, output sel_s);
  modport dst (input pg_s, input pg_rise, input done_rise, input sel_s);
endinterface

`default_nettype wire

// >>> lwwd_sync.sv
// Purpose: two-flop synchronisers and edge detection for the pins
// Assumes: pins are asynchronous to CLK; done pulses last 100 ns or more
// Notes: first stages feed second stages only

`timescale 1ns/1ps
`default_nettype none

module lwwd_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // raw pins
  input wire logic pg_pin,
  input wire logic done_pin,
  input wire logic [lwwd_pkg::SEL_W-1:0] sel_pin,
  // synchronised view
  lwwd_sync_if.src sif
);

  logic [4:0] meta_r;
  logic [4:0] sync_r;
  logic pg_d_r;
  logic done_d_r;

  // two-flop synchronisers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= 5'h00;
      sync_r <= 5'h00;
    end else begin
      meta_r <= {sel_pin, done_pin, pg_pin};
      sync_r <= meta_r;
    end
  end

  // delayed copies for edge detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pg_d_r <= 1'b0;
      done_d_r <= 1'b0;
    end else begin
      pg_d_r <= sync_r[0];
      done_d_r <= sync_r[1];
    end
  end

  // level and edge outputs
  assign sif.pg_s = sync_r[0];
  assign sif.pg_rise = sync_r[0] & ~pg_d_r;
  assign sif.done_rise = sync_r[1] & ~done_d_r;
  assign sif.sel_s = sync_r[4:2];

endmodule

`default_nettype wire

// >>> lwwd_top.sv
// Purpose: long-interval timer with watchdog and supply supervisor
// Assumes: 40 MHz CLK; base oscillator emulated by a half-period divider
// Notes: registers reached over classic Wishbone, one-cycle answer
//
// Functional notes
// - select pins pick one of eight periods
// - period equals factor N base periods
// - timing runs only while power good high
// - power good fall clears outputs asynchronously
// - supply drop latched, reset follows next period
// - power good rise restarts both counters
// - first period after rise ends in reset
// - done in period gives wake next time
// - no done in period gives reset
// - wake lasts two base periods unless aborted
// - cal follows half period, one period wide
// - only rising edges of done count
// - only first done per period counts
// - done leaves period counter running
// - done during wake or cal ends both
// - done held low gives endless resets
// - done tied to cal gives wakes

`timescale 1ns/1ps
`default_nettype none

module lwwd_top #(
  parameter int HALF_CYCLES = lwwd_pkg::OSC_HALF_CYCLES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // supply supervisor
  input wire logic POWER_GOOD_IN,
  // strapped interval select
  input wire logic INTERVAL_SELECT_BIT0,
  input wire logic INTERVAL_SELECT_BIT1,
  input wire logic INTERVAL_SELECT_BIT2,
  // host handshake
  input wire logic HOST_DONE_IN,
  output logic WAKE_PULSE_OUT,
  output logic CAL_PULSE_OUT,
  output logic HOST_RESET_N,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------

  // last half tick of a delay period, 2*N-1
  function automatic logic [lwwd_pkg::HCNT_W-1:0] last_half(
    input logic [lwwd_pkg::SEL_W-1:0] sel
  );
    logic [lwwd_pkg::HCNT_W-1:0] n;
    n = 14'h0040;
    case (sel)
      3'h0: n = 14'h0040;
      3'h1: n = 14'h0080;
      3'h2: n = 14'h0100;
      3'h3: n = 14'h0200;
      3'h4: n = 14'h0280;
      3'h5: n = 14'h0400;
      3'h6: n = 14'h0800;
      3'h7: n = 14'h1000;
      default: n = 14'h0040;
    endcase
    last_half = (n << 1) - 14'h0001;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------

  lwwd_sync_if sif ();

  lwwd_sync u_sync (
    .clk(CLK),
    .rst(RST),
    .pg_pin(POWER_GOOD_IN),
    .done_pin(HOST_DONE_IN),
    .sel_pin({INTERVAL_SELECT_BIT2, INTERVAL_SELECT_BIT1, INTERVAL_SELECT_BIT0}),
    .sif(sif.src)
  );

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------

  logic [3:0] ctrl_r;
  logic [lwwd_pkg::HDIV_W-1:0] hdiv_r;
  logic [lwwd_pkg::HCNT_W-1:0] hcnt_r;
  lwwd_pkg::lwwd_pulse_e kind_r;
  lwwd_pkg::lwwd_pulse_e kind_nxt;
  logic [1:0] seq_r;
  logic [1:0] seq_nxt;
  logic cut_r;
  logic fed_r;
  logic drop_r;
  logic wake_r;
  logic cal_r;
  logic host_reset_n_r;
  logic ack_r;
  logic [31:0] dat_r;

  wire pg_arst;
  wire [lwwd_pkg::SEL_W-1:0] act_sel;
  wire [lwwd_pkg::HCNT_W-1:0] period_last;
  wire htick;
  wire period_end;
  wire done_ev;
  wire abort;
  wire go_reset;
  wire go_wake;
  wire pulse_last;
  wire wake_nxt;
  wire cal_nxt;
  wire host_reset_n_nxt;
  wire cut_nxt;
  wire wb_req;
  wire wb_wr;
  wire [31:0] rd_mux;
  wire [31:0] status_w;

  // ----------------------------------------------------------------
  // interval selection and timing
  // ----------------------------------------------------------------

  assign act_sel = ctrl_r[lwwd_pkg::CTRL_OVR_EN_BIT] ?
    ctrl_r[lwwd_pkg::CTRL_SEL_LSB +: lwwd_pkg::SEL_W] : sif.sel_s;

  assign period_last = last_half(act_sel);

  // oscillator runs only with power good
  assign htick = sif.pg_s &&
    (hdiv_r == lwwd_pkg::HDIV_W'(HALF_CYCLES - 1));

  assign period_end = htick && (hcnt_r >= period_last);

  // half-period divider
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      hdiv_r <= '0;
    end else if (!sif.pg_s || sif.pg_rise || htick) begin
      hdiv_r <= '0;
    end else begin
      hdiv_r <= hdiv_r + 1'b1;
    end
  end

  // delay-period counter in half base periods
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      hcnt_r <= '0;
    end else if (!sif.pg_s || sif.pg_rise || period_end) begin
      hcnt_r <= '0;
    end else if (htick) begin
      hcnt_r <= hcnt_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // watchdog state
  // ----------------------------------------------------------------

  assign done_ev = sif.done_rise && sif.pg_s && !fed_r;

  // fed flag, set wins over clear
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      fed_r <= 1'b0;
    end else if (done_ev) begin
      fed_r <= 1'b1;
    end else if (!sif.pg_s || sif.pg_rise || period_end) begin
      fed_r <= 1'b0;
    end
  end

  // async set while supply is bad or in reset
  assign pg_arst = RST | ~POWER_GOOD_IN;

  always_ff @(posedge CLK or posedge pg_arst) begin
    if (pg_arst) begin
      drop_r <= 1'b1;
    end else if (go_reset) begin
      drop_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pulse sequencer
  // ----------------------------------------------------------------

  // no done means reset every time
  assign go_wake = period_end && fed_r && !drop_r;
  assign go_reset = period_end && !(fed_r && !drop_r);

  assign abort = done_ev && (wake_r || cal_r);

  // cal cut short, reset pulse runs on
  assign cut_nxt = (kind_nxt == lwwd_pkg::PK_RESET) && !go_reset && (cut_r || abort);

  // last half tick of the running pulse
  assign pulse_last = htick && (
    (kind_r == lwwd_pkg::PK_WAKE && seq_r == lwwd_pkg::SEQ_WAKE_LAST) ||
    (kind_r == lwwd_pkg::PK_RESET && seq_r == lwwd_pkg::SEQ_RST_LAST));

  // next pulse kind and step
  always_comb begin
    kind_nxt = kind_r;
    seq_nxt = seq_r;
    case (kind_r)
      lwwd_pkg::PK_IDLE: begin
        seq_nxt = 2'h0;
      end
      lwwd_pkg::PK_RESET: begin
        if (pulse_last) begin
          kind_nxt = lwwd_pkg::PK_IDLE;
        end else if (htick) begin
          seq_nxt = seq_r + 2'h1;
        end
      end
      lwwd_pkg::PK_WAKE: begin
        if (pulse_last || abort) begin
          kind_nxt = lwwd_pkg::PK_IDLE;
        end else if (htick) begin
          seq_nxt = seq_r + 2'h1;
        end
      end
      default: begin
        kind_nxt = lwwd_pkg::PK_IDLE;
        seq_nxt = 2'h0;
      end
    endcase
    if (go_wake) begin
      kind_nxt = lwwd_pkg::PK_WAKE;
      seq_nxt = 2'h0;
    end else if (go_reset) begin
      kind_nxt = lwwd_pkg::PK_RESET;
      seq_nxt = 2'h0;
    end
    if (!sif.pg_s) begin
      kind_nxt = lwwd_pkg::PK_IDLE;
      seq_nxt = 2'h0;
    end
  end

  // sequencer registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      kind_r <= lwwd_pkg::PK_IDLE;
      seq_r <= 2'h0;
      cut_r <= 1'b0;
    end else begin
      kind_r <= kind_nxt;
      seq_r <= seq_nxt;
      cut_r <= cut_nxt;
    end
  end

  // ----------------------------------------------------------------
  // output decode
  // ----------------------------------------------------------------

  assign wake_nxt = (kind_nxt == lwwd_pkg::PK_WAKE);

  // cal from half period, one period
  assign cal_nxt = (kind_nxt != lwwd_pkg::PK_IDLE) && !cut_nxt &&
    (seq_nxt >= lwwd_pkg::SEQ_CAL_ON) && (seq_nxt < lwwd_pkg::SEQ_CAL_OFF);

  assign host_reset_n_nxt = !((kind_nxt == lwwd_pkg::PK_RESET) &&
    (seq_nxt < lwwd_pkg::SEQ_RST_OFF));

  // outputs cleared by power good fall
  always_ff @(posedge CLK or posedge pg_arst) begin
    if (pg_arst) begin
      wake_r <= 1'b0;
      cal_r <= 1'b0;
      host_reset_n_r <= 1'b1;
    end else begin
      wake_r <= wake_nxt;
      cal_r <= cal_nxt;
      host_reset_n_r <= host_reset_n_nxt;
    end
  end

  assign WAKE_PULSE_OUT = wake_r;
  assign CAL_PULSE_OUT = cal_r;
  assign HOST_RESET_N = host_reset_n_r;

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------

  // request decode, one answer per request
  assign wb_req = WB_CYC_I && WB_STB_I && !ack_r;
  assign wb_wr = wb_req && WB_WE_I;

  // status word
  assign status_w = {23'h00_0000, host_reset_n_r, cal_r, wake_r, act_sel,
    fed_r, drop_r, sif.pg_s};

  // read mux, unmapped reads as zero
  assign rd_mux =
    (WB_ADR_I == lwwd_pkg::ADDR_CTRL) ? {28'h000_0000, ctrl_r} :
    (WB_ADR_I == lwwd_pkg::ADDR_STATUS) ? status_w :
    (WB_ADR_I == lwwd_pkg::ADDR_COUNT) ? {18'h0_0000, hcnt_r} :
    32'h0000_0000;

  // control register write, low byte lane
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_r <= lwwd_pkg::CTRL_RESET;
    end else if (wb_wr && WB_SEL_I[0] && WB_ADR_I == lwwd_pkg::ADDR_CTRL) begin
      ctrl_r <= WB_DAT_I[3:0];
    end
  end

  // acknowledge and read data
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= wb_req;
      dat_r <= wb_req ? rd_mux : 32'h0000_0000;
    end
  end

  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = dat_r;

endmodule

`default_nettype wire

// >>> lwwd_top_asserts.sv
// Purpose: port checks for the wake watchdog top
// Assumes: one clock, RST async active high
// Notes: widths counted in clocks of half ticks
`timescale 1ns/1ps
`default_nettype none
module lwwd_top_asserts #(
  parameter int HALF_CYCLES = lwwd_pkg::OSC_HALF_CYCLES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // pins
  input wire logic POWER_GOOD_IN,
  input wire logic HOST_DONE_IN,
  input wire logic WAKE_PULSE_OUT,
  input wire logic CAL_PULSE_OUT,
  input wire logic HOST_RESET_N,
  // bus
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O
);
  // ------------
  // helpers
  // ------------
  localparam int H = HALF_CYCLES;
  logic [15:0] lo_r, cal_r, wk_r;
  logic [7:0] age_r;
  logic dn_q_r, fed_r;
  wire dn_rise = HOST_DONE_IN & ~dn_q_r;
  wire go = (WAKE_PULSE_OUT & (wk_r == 16'h0000)) | (~HOST_RESET_N & (lo_r == 16'h0000));
  // run lengths, age of last done, fed flag
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      lo_r <= 16'h0000;
      cal_r <= 16'h0000;
      wk_r <= 16'h0000;
      age_r <= 8'hff;
      dn_q_r <= 1'b0;
      fed_r <= 1'b0;
    end else begin
      lo_r <= HOST_RESET_N ? 16'h0000 : lo_r + 16'h0001;
      cal_r <= CAL_PULSE_OUT ? cal_r + 16'h0001 : 16'h0000;
      wk_r <= WAKE_PULSE_OUT ? wk_r + 16'h0001 : 16'h0000;
      age_r <= dn_rise ? 8'h00 : age_r + {7'h00, age_r != 8'hff};
      dn_q_r <= HOST_DONE_IN;
      fed_r <= go ? 1'b0 : fed_r | dn_rise;
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST || !POWER_GOOD_IN);
  property p_rst_w;
    $rose(HOST_RESET_N) |-> lo_r == 16'(2 * H);
  endproperty
  a_rst_w: assert property (p_rst_w) else $error("reset width wrong");
  property p_cal_w;
    $fell(CAL_PULSE_OUT) && age_r > 8'h0c |-> cal_r == 16'(2 * H);
  endproperty
  a_cal_w: assert property (p_cal_w) else $error("cal width wrong");
  property p_wk_w;
    $fell(WAKE_PULSE_OUT) && age_r > 8'h0c |-> wk_r == 16'(4 * H);
  endproperty
  a_wk_w: assert property (p_wk_w) else $error("wake width wrong");
  property p_cal_wk;
    $rose(WAKE_PULSE_OUT) ##H WAKE_PULSE_OUT |-> $rose(CAL_PULSE_OUT);
  endproperty
  a_cal_wk: assert property (p_cal_wk) else $error("cal late after wake");
  property p_cal_rs;
    $fell(HOST_RESET_N) |-> ##H $rose(CAL_PULSE_OUT);
  endproperty
  a_cal_rs: assert property (p_cal_rs) else $error("cal late after reset");
  property p_pg_clr;
    disable iff (RST) !POWER_GOOD_IN |-> !WAKE_PULSE_OUT && !CAL_PULSE_OUT && HOST_RESET_N;
  endproperty
  a_pg_clr: assert property (p_pg_clr) else $error("outputs active in power loss");
  property p_fed;
    $rose(WAKE_PULSE_OUT) |-> fed_r;
  endproperty
  a_fed: assert property (p_fed) else $error("wake without done");
  property p_cut;
    $rose(HOST_DONE_IN) && CAL_PULSE_OUT && !fed_r |-> ##3 !CAL_PULSE_OUT;
  endproperty
  a_cut: assert property (p_cut) else $error("cal not ended by done");
  property p_ack;
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer wrong");
  c_wake: cover property ($rose(WAKE_PULSE_OUT));
  c_rst: cover property ($fell(HOST_RESET_N));
  c_abort: cover property ($fell(WAKE_PULSE_OUT) && wk_r < 16'(4 * H));
endmodule
bind lwwd_top lwwd_top_asserts #(.HALF_CYCLES(HALF_CYCLES)) u_chk (.CLK(CLK), .RST(RST),
  .POWER_GOOD_IN(POWER_GOOD_IN), .HOST_DONE_IN(HOST_DONE_IN), .WAKE_PULSE_OUT(WAKE_PULSE_OUT),
  .CAL_PULSE_OUT(CAL_PULSE_OUT), .HOST_RESET_N(HOST_RESET_N), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O));
`default_nettype wire

// >>> lwwd_host.sv
// Purpose: host model driving the done pin
// Assumes: pins seen on the bench clock
// Notes: mode 0 low, 1 tied to cal, 2 timed pulse
`timescale 1ns/1ps
`default_nettype none
module lwwd_host (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // behaviour
  input wire logic [1:0] mode,
  input wire logic [8:0] dly,
  // device pins
  input wire logic wake,
  input wire logic cal,
  input wire logic rst_n,
  output logic done
);
  // ------------
  // done maker
  // ------------
  logic wk_q_r, rn_q_r, pls_r;
  logic [8:0] cnt_r;
  wire start = (wake & ~wk_q_r) | (~rst_n & rn_q_r);
  // done after pulse start, 4 clocks high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wk_q_r <= 1'b0;
      rn_q_r <= 1'b1;
      cnt_r <= 9'h000;
      pls_r <= 1'b0;
    end else begin
      wk_q_r <= wake;
      rn_q_r <= rst_n;
      cnt_r <= start ? 9'h001 : (cnt_r != 9'h000 && cnt_r < dly + 9'h005) ? cnt_r + 9'h001 : 9'h000;
      pls_r <= mode == 2'h2 && cnt_r > dly && cnt_r <= dly + 9'h004;
    end
  end
  // tied to cal in mode 1, else the timed pulse, low unless mode 2
  assign done = (mode == 2'h1) ? cal : pls_r;
endmodule
`default_nettype wire

// >>> lwwd_top_tb.sv
// Purpose: self-checking bench for the wake watchdog top
// Assumes: HALF_CYCLES 4, so a period is 8N clocks
// Notes: bus register checks first, then code table, then hand tests
`timescale 1ns/1ps
`default_nettype none
module lwwd_top_tb;
  // ------------
  // signals
  // ------------
  localparam int HC = 4;
  localparam int LIM = 40000;
  logic CLK, RST, pg, cyc, stb, we, wake, cal, host_reset_n, ack, done;
  logic [2:0] sel;
  logic [3:0] adr, bsel;
  logic [31:0] wdat, rdat, dat_o;
  logic [1:0] mode;
  logic [8:0] dly;
  int err_total, check_count, n, w;
  int rows[8][2] = '{'{0,64}, '{1,128}, '{2,256}, '{3,512}, '{4,640}, '{5,1024}, '{6,2048}, '{7,4096}};
  lwwd_top #(.HALF_CYCLES(HC)) DUT (.CLK(CLK), .RST(RST), .POWER_GOOD_IN(pg),
    .INTERVAL_SELECT_BIT0(sel[0]), .INTERVAL_SELECT_BIT1(sel[1]), .INTERVAL_SELECT_BIT2(sel[2]),
    .HOST_DONE_IN(done), .WAKE_PULSE_OUT(wake), .CAL_PULSE_OUT(cal), .HOST_RESET_N(host_reset_n),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(bsel),
    .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack));
  lwwd_host u_host (.clk(CLK), .rst(RST), .mode(mode), .dly(dly), .wake(wake), .cal(cal),
    .rst_n(host_reset_n), .done(done));
  // compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // verdict and stop
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one classic bus cycle
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge CLK);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do begin
      @(posedge CLK);
      k++;
    end while (ack !== 1'b1 && k < 50);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      err_total++;
      conclude();
    end
  endtask
  // wait for reset fall (s 0) or wake rise (s 1)
  task automatic wedge(input int s, output int n);
    n = 0;
    while ((s ? wake : ~host_reset_n) !== 1'b0 && n < LIM) begin
      @(negedge CLK);
      n++;
    end
    while ((s ? wake : ~host_reset_n) !== 1'b1 && n < LIM) begin
      @(negedge CLK);
      n++;
    end
    if (n >= LIM) begin
      err_total++;
      conclude();
    end
  endtask
  // wake high width
  task automatic wwid(output int n);
    n = 0;
    while (wake === 1'b1 && n < 100) begin
      @(negedge CLK);
      n++;
    end
  endtask
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  // ------------
  // main sequence
  // ------------
  initial begin
    // power good held high except in the drop test
    {RST, pg, cyc, stb, we, sel, adr, wdat, mode, dly} = {2'b11, 3'h0, 3'h0, 36'h0, 11'h0};
    bsel = 4'hf;
    err_total = 0;
    check_count = 0;
    repeat (4) @(posedge CLK);
    RST <= 1'b0;
    chk({29'h0, wake, cal, host_reset_n}, 32'h0000_0001);
    wb(1'b0, lwwd_pkg::ADDR_CTRL, 32'h0000_0000);
    chk(rdat, 32'(lwwd_pkg::CTRL_RESET));
    wb(1'b1, lwwd_pkg::ADDR_CTRL, 32'h0000_000f);
    wb(1'b0, lwwd_pkg::ADDR_STATUS, 32'h0000_0000);
    chk(32'(rdat[lwwd_pkg::ST_SEL_LSB+:3]), 32'h0000_0007);
    wb(1'b1, lwwd_pkg::ADDR_CTRL, 32'h0000_0000);
    bsel <= 4'he;
    wb(1'b1, lwwd_pkg::ADDR_CTRL, 32'h0000_000f);
    bsel <= 4'hf;
    wb(1'b0, lwwd_pkg::ADDR_CTRL, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    wb(1'b0, 4'hc, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    // codes and periods, done held low
    for (int i = 0; i < 8; i++) begin
      @(posedge CLK);
      sel <= 3'(rows[i][0]);
      repeat (4) @(posedge CLK);
      wb(1'b0, lwwd_pkg::ADDR_STATUS, 32'h0000_0000);
      chk(32'(rdat[lwwd_pkg::ST_SEL_LSB+:3]), 32'(rows[i][0]));
      if (rows[i][1] <= 640) begin
        wedge(0, n);
        wedge(0, n);
        chk(32'(n), 32'(2 * HC * rows[i][1]));
      end
    end
    @(posedge CLK);
    sel <= 3'h0;
    mode <= 2'h1;
    wedge(1, n);
    chk(32'(n < 1600), 32'h0000_0001);
    @(posedge CLK);
    mode <= 2'h2;
    dly <= 9'h028;
    wedge(1, n);
    wwid(w);
    wedge(1, n);
    chk(32'(w), 32'(4 * HC));
    chk(32'(w + n), 32'(2 * HC * 64));
    @(posedge CLK);
    dly <= 9'h006;
    wedge(1, n);
    wwid(w);
    chk(32'(w < 4 * HC), 32'h0000_0001);
    chk(32'(cal), 32'h0000_0000);
    wedge(1, n);
    @(posedge CLK);
    pg <= 1'b0;
    @(negedge CLK);
    chk({29'h0, wake, cal, host_reset_n}, 32'h0000_0001);
    repeat (20) @(posedge CLK);
    wb(1'b0, lwwd_pkg::ADDR_STATUS, 32'h0000_0000);
    chk(32'(rdat[lwwd_pkg::ST_DROP_BIT]), 32'h0000_0001);
    chk(32'(rdat[lwwd_pkg::ST_PG_BIT]), 32'h0000_0000);
    wb(1'b0, lwwd_pkg::ADDR_COUNT, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    @(posedge CLK);
    pg <= 1'b1;
    wedge(0, n);
    chk(32'(n >= 2 * HC * 64 && n <= 2 * HC * 64 + 8), 32'h0000_0001);
    conclude();
  end
endmodule
`default_nettype wire
